// ==== rtl/sowr_regs.sv ====
// System options, part number and periodic wakeup timer register block behind an APB slave.
//
// Functional notes
// R1 - Options register always readable; bits 3 and 2 read as zero.
// R2 - Only the first options write after reset is taken; later writes ignored.
// R3 - Options bit 7 enables the watchdog, reset value 1.
// R4 - Options bit 6 picks watchdog timeout 2^13 or 2^18 bus cycles, reset 1.
// R5 - Options bit 5 permits halt, reset 0; halt when refused forces illegal-opcode reset.
// R6 - Options bit 1 selects debug pin function (1) or output-only pin (0), reset 1.
// R7 - Read-only 12-bit part number split over high bits 3:0 and low bits 7:0.
// R8 - Wakeup bit 7 is a read-only flag set when the wakeup timer expires.
// R9 - Wakeup bit 6 write one clears the flag; reads as zero.
// R10 - Wakeup bit 5 selects internal oscillator (0) or external clock (1).
// R11 - Wakeup bit 4 enables the wakeup interrupt.
// R12 - Internal oscillator periods from 9.2 ms doubling to 1177.6 ms, tick 1.15 ms.
// R13 - External clock: code 000 disables, others divide by 256 up to 32768.
// R14 - Internal wakeup oscillator runs independently of the main clock.
// R15 - Unimplemented wakeup register bits read as zero.
// R16 - Software should write the options register once during start-up to lock it.
// R17 - Wakeup interrupt request is high while flag and enable are both set.
`timescale 1ns/1ns
`default_nettype none

module sowr_regs
  import sowr_pkg::*;
#(
  // Arbitrary neutral value.
  parameter logic [PART_W-1:0] PART_NUMBER = 12'h3a5
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire sowr_apb_req_t apb_req,
  output sowr_apb_rsp_t apb_rsp,
  input wire logic wakeup_osc_clk,
  input wire logic ext_clk,
  input wire logic stop_exec,
  output logic watchdog_enable,
  output logic watchdog_long_timeout,
  output logic halt_permit,
  output logic stop_granted,
  output logic illegal_opcode_reset,
  output logic debug_pin_enable,
  output logic wakeup_irq,
  output logic irq
);

  typedef struct packed {
    logic opt_written;
    logic wd_en;
    logic wd_long;
    logic halt;
    logic dbg_pin;
    logic wk_flag;
    logic wk_clksel;
    logic wk_ie;
    logic [WK_SEL_W-1:0] wk_sel;
    logic [WK_CNT_W-1:0] wk_cnt;
    logic [SYNC_W-1:0] osc_sync;
    logic osc_lvl;
    logic [SYNC_W-1:0] ext_sync;
    logic ext_lvl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic wk_irq;
    logic illegal_rst;
    logic stop_ok;
    logic pready;
    logic pslverr;
    logic [APB_DW-1:0] prdata;
  } sowr_state_t;

  sowr_state_t state_reg;
  sowr_state_t state_next;

  // Number of source ticks in one wakeup period for the selected source and code.
  function automatic logic [WK_CNT_W-1:0] wk_target(input logic ext, input logic [WK_SEL_W-1:0] sel);
    logic [WK_CNT_W-1:0] t;
    t = WK_INT_BASE_TICKS << sel;
    if (ext) begin
      case (sel)
        3'h1: t = WK_EXT_DIV1;
        3'h2: t = WK_EXT_DIV2;
        3'h3: t = WK_EXT_DIV3;
        3'h4: t = WK_EXT_DIV4;
        3'h5: t = WK_EXT_DIV5;
        3'h6: t = WK_EXT_DIV6;
        3'h7: t = WK_EXT_DIV7;
        default: t = '0;
      endcase
    end
    return t;
  endfunction : wk_target

  // Register decode, used only by the unmapped check; the read mux decodes with its own case.
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    return (a == OFS_SYSTEM_OPTIONS) || (a == OFS_PART_NUMBER_HIGH) || (a == OFS_PART_NUMBER_LOW) ||
           (a == OFS_WAKEUP_STATUS_CONTROL) || (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK);
  endfunction : is_mapped

  logic access;
  logic wr_acc;
  logic wr_opt;
  logic wr_wk;
  logic osc_rise;
  logic ext_rise;
  logic wk_tick;
  logic wk_run;
  logic wk_hit;
  logic [WK_CNT_W-1:0] wk_limit;
  logic [IRQ_W-1:0] irq_set;
  logic [APB_DW-1:0] rd_data;

  always_comb begin
    state_next = state_reg;
    access = apb_req.psel && apb_req.penable && state_reg.pready;
    wr_acc = access && apb_req.pwrite;
    wr_opt = wr_acc && (apb_req.paddr == OFS_SYSTEM_OPTIONS);
    wr_wk = wr_acc && (apb_req.paddr == OFS_WAKEUP_STATUS_CONTROL);

    // Pin inputs: a level counts once the second and third stages agree.
    state_next.osc_sync = {state_reg.osc_sync[SYNC_W-2:0], wakeup_osc_clk};
    state_next.ext_sync = {state_reg.ext_sync[SYNC_W-2:0], ext_clk};
    osc_rise = 1'b0;
    ext_rise = 1'b0;
    if (state_reg.osc_sync[2] == state_reg.osc_sync[1]) begin
      state_next.osc_lvl = state_reg.osc_sync[2];
      osc_rise = state_reg.osc_sync[2] && !state_reg.osc_lvl;
    end
    if (state_reg.ext_sync[2] == state_reg.ext_sync[1]) begin
      state_next.ext_lvl = state_reg.ext_sync[2];
      ext_rise = state_reg.ext_sync[2] && !state_reg.ext_lvl;
    end

    // The internal oscillator arrives on its own pin, but its edges are sampled and counted on clk_sys. [R14]
    wk_tick = state_reg.wk_clksel ? ext_rise : osc_rise; // [R10]
    wk_run = !(state_reg.wk_clksel && (state_reg.wk_sel == '0)); // [R13]
    wk_limit = wk_target(state_reg.wk_clksel, state_reg.wk_sel) - WK_CNT_W'(1); // [R12] [R13]
    wk_hit = wk_run && wk_tick && (state_reg.wk_cnt >= wk_limit);
    if (!wk_run) begin
      state_next.wk_cnt = '0;
    end else if (wk_tick) begin
      state_next.wk_cnt = wk_hit ? '0 : state_reg.wk_cnt + WK_CNT_W'(1);
    end

    // Options register: the first write locks it until the next reset. [R2]
    if (wr_opt && !state_reg.opt_written) begin
      state_next.opt_written = 1'b1;
      state_next.wd_en = apb_req.pwdata[OPT_WD_EN_BIT]; // [R3]
      state_next.wd_long = apb_req.pwdata[OPT_WD_LONG_BIT]; // [R4]
      state_next.halt = apb_req.pwdata[OPT_HALT_BIT]; // [R5]
      state_next.dbg_pin = apb_req.pwdata[OPT_DBG_PIN_BIT]; // [R6]
    end

    // A halt request without permission becomes an illegal-opcode reset request. [R5]
    state_next.illegal_rst = stop_exec && !state_reg.halt;
    state_next.stop_ok = stop_exec && state_reg.halt;

    // Wakeup control; a timeout in the same cycle as a clear keeps the flag set.
    if (wr_wk) begin
      state_next.wk_clksel = apb_req.pwdata[WK_CLKSEL_BIT]; // [R10]
      state_next.wk_ie = apb_req.pwdata[WK_IE_BIT]; // [R11]
      state_next.wk_sel = apb_req.pwdata[WK_SEL_LSB +: WK_SEL_W];
      state_next.wk_cnt = '0;
      if (apb_req.pwdata[WK_CLR_BIT]) begin
        state_next.wk_flag = 1'b0; // [R9]
      end
    end
    if (wk_hit) begin
      state_next.wk_flag = 1'b1; // [R8]
    end
    state_next.wk_irq = state_next.wk_flag && state_next.wk_ie; // [R17]

    // Sticky event bits, write one to clear; new events win over a clear.
    irq_set = '0;
    irq_set[IRQ_WAKEUP_BIT] = wk_hit;
    irq_set[IRQ_OPT_REFUSED_BIT] = wr_opt && state_reg.opt_written;
    if (wr_acc && (apb_req.paddr == OFS_IRQ_STATUS)) begin
      state_next.irq_stat = state_reg.irq_stat & ~apb_req.pwdata[IRQ_W-1:0];
    end
    if (wr_acc && (apb_req.paddr == OFS_IRQ_MASK)) begin
      state_next.irq_mask = apb_req.pwdata[IRQ_W-1:0];
    end
    state_next.irq_stat = state_next.irq_stat | irq_set;
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

    // Read mux; unimplemented bits stay zero.
    rd_data = '0;
    case (apb_req.paddr)
      OFS_SYSTEM_OPTIONS: begin
        rd_data[OPT_WD_EN_BIT] = state_reg.wd_en; // [R1]
        rd_data[OPT_WD_LONG_BIT] = state_reg.wd_long;
        rd_data[OPT_HALT_BIT] = state_reg.halt;
        rd_data[OPT_DBG_PIN_BIT] = state_reg.dbg_pin;
      end
      OFS_PART_NUMBER_HIGH: begin
        rd_data[3:0] = PART_NUMBER[11:8]; // [R7]
      end
      OFS_PART_NUMBER_LOW: begin
        rd_data[7:0] = PART_NUMBER[7:0]; // [R7]
      end
      OFS_WAKEUP_STATUS_CONTROL: begin
        rd_data[WK_FLAG_BIT] = state_reg.wk_flag; // [R15]
        rd_data[WK_CLKSEL_BIT] = state_reg.wk_clksel;
        rd_data[WK_IE_BIT] = state_reg.wk_ie;
        rd_data[WK_SEL_LSB +: WK_SEL_W] = state_reg.wk_sel;
      end
      OFS_IRQ_STATUS: begin
        rd_data[IRQ_W-1:0] = state_reg.irq_stat;
      end
      OFS_IRQ_MASK: begin
        rd_data[IRQ_W-1:0] = state_reg.irq_mask;
      end
      default: begin
        rd_data = '0;
      end
    endcase

    // APB: one wait state, so pready and prdata come straight from flip-flops.
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable && !state_reg.pready) begin
      state_next.pready = 1'b1;
      state_next.pslverr = !is_mapped(apb_req.paddr);
      state_next.prdata = apb_req.pwrite ? '0 : rd_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.wd_en <= OPT_WD_EN_RST; // [R3]
      state_reg.wd_long <= OPT_WD_LONG_RST; // [R4]
      state_reg.halt <= OPT_HALT_RST; // [R5]
      state_reg.dbg_pin <= OPT_DBG_PIN_RST; // [R6]
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp.pready = state_reg.pready;
  assign apb_rsp.pslverr = state_reg.pslverr;
  assign apb_rsp.prdata = state_reg.prdata;
  assign watchdog_enable = state_reg.wd_en;
  assign watchdog_long_timeout = state_reg.wd_long;
  assign halt_permit = state_reg.halt;
  assign stop_granted = state_reg.stop_ok;
  assign illegal_opcode_reset = state_reg.illegal_rst;
  assign debug_pin_enable = state_reg.dbg_pin;
  assign wakeup_irq = state_reg.wk_irq;
  assign irq = state_reg.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  logic rd_opt_done;
  logic rd_low_done;
  logic rd_wk_done;
  assign rd_opt_done = state_reg.pready && !apb_req.pwrite && (apb_req.paddr == OFS_SYSTEM_OPTIONS);
  assign rd_low_done = state_reg.pready && !apb_req.pwrite && (apb_req.paddr == OFS_PART_NUMBER_LOW);
  assign rd_wk_done = state_reg.pready && !apb_req.pwrite && (apb_req.paddr == OFS_WAKEUP_STATUS_CONTROL);

  a_opt_read_zero: assert property (rd_opt_done |-> apb_rsp.prdata[3:2] == 2'h0) // [R1]
    else $error("options read shows nonzero unimplemented bits");
  a_opt_write_lock: assert property (wr_opt && state_reg.opt_written |=>
      $stable({watchdog_enable, watchdog_long_timeout, halt_permit, debug_pin_enable})) // [R2]
    else $error("locked options register changed");
  a_watchdog_default: assert property ($fell(srst) |-> watchdog_enable && watchdog_long_timeout) // [R3] [R4]
    else $error("watchdog fields not at reset value");
  a_halt_refused: assert property (stop_exec && !halt_permit |=> illegal_opcode_reset && !stop_granted) // [R5]
    else $error("refused halt did not force illegal-opcode reset");
  a_debug_default: assert property ($fell(srst) |-> debug_pin_enable && !halt_permit) // [R6] [R5]
    else $error("debug pin or halt permit not at reset value");
  a_part_low: assert property (rd_low_done |-> apb_rsp.prdata == APB_DW'(PART_NUMBER[7:0])) // [R7]
    else $error("part number low read wrong");
  a_flag_on_hit: assert property (wk_hit |=> state_reg.wk_flag && (wakeup_irq == state_reg.wk_ie)) // [R8] [R17]
    else $error("wakeup timeout did not raise the flag");
  a_flag_clear: assert property (wr_wk && apb_req.pwdata[WK_CLR_BIT] && !wk_hit |=> !state_reg.wk_flag) // [R9]
    else $error("flag clear did not take effect");
  a_wk_read_zero: assert property (rd_wk_done |-> apb_rsp.prdata[WK_CLR_BIT] == 1'b0 &&
      apb_rsp.prdata[3] == 1'b0 && apb_rsp.prdata[APB_DW-1:8] == '0) // [R9] [R15]
    else $error("wakeup read shows nonzero unimplemented bits");
  a_ext_disabled: assert property (state_reg.wk_clksel && state_reg.wk_sel == '0 |-> !wk_hit) // [R13]
    else $error("disabled external wakeup timer expired");
  a_irq_level: assert property (wakeup_irq |-> $past(state_next.wk_flag && state_next.wk_ie)) // [R17] [R11]
    else $error("wakeup request without flag and enable");

  c_opt_write: cover property (wr_opt && !state_reg.opt_written);
  c_wakeup_hit: cover property (wk_hit && !state_reg.wk_clksel);
  c_ext_hit: cover property (wk_hit && state_reg.wk_clksel);
  c_illegal: cover property (illegal_opcode_reset);

endmodule : sowr_regs

`default_nettype wire

// ==== common/sowr_pkg.sv ====
// Package with register map, field positions and carriers for the system options and wakeup registers.
package sowr_pkg;

  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // Register byte addresses.
  localparam logic [APB_AW-1:0] OFS_SYSTEM_OPTIONS = 8'h00;
  localparam logic [APB_AW-1:0] OFS_PART_NUMBER_HIGH = 8'h04;
  localparam logic [APB_AW-1:0] OFS_PART_NUMBER_LOW = 8'h08;
  localparam logic [APB_AW-1:0] OFS_WAKEUP_STATUS_CONTROL = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 8'h14;

  // Options register fields.
  localparam int unsigned OPT_WD_EN_BIT = 7;
  localparam int unsigned OPT_WD_LONG_BIT = 6;
  localparam int unsigned OPT_HALT_BIT = 5;
  localparam int unsigned OPT_DBG_PIN_BIT = 1;
  localparam logic OPT_WD_EN_RST = 1'b1;
  localparam logic OPT_WD_LONG_RST = 1'b1;
  localparam logic OPT_HALT_RST = 1'b0;
  localparam logic OPT_DBG_PIN_RST = 1'b1;

  // Watchdog timeouts in bus clock cycles.
  localparam int unsigned WD_SHORT_LOG2 = 13;
  localparam int unsigned WD_LONG_LOG2 = 18;

  // Wakeup status/control fields.
  localparam int unsigned WK_FLAG_BIT = 7;
  localparam int unsigned WK_CLR_BIT = 6;
  localparam int unsigned WK_CLKSEL_BIT = 5;
  localparam int unsigned WK_IE_BIT = 4;
  localparam int unsigned WK_SEL_LSB = 0;
  localparam int unsigned WK_SEL_W = 3;
  localparam int unsigned WK_CNT_W = 16;

  // Internal oscillator tick is 1.15 ms; code 000 gives 9.2 ms, i.e. 8 ticks, doubling per code.
  localparam int unsigned WK_TICK_NS = 1150000;
  localparam int unsigned WK_BASE_PERIOD_NS = 9200000;
  localparam logic [WK_CNT_W-1:0] WK_INT_BASE_TICKS = WK_CNT_W'(WK_BASE_PERIOD_NS / WK_TICK_NS);

  // External clock divide ratios for codes 001..111 (code 000 disables the timer).
  localparam logic [WK_CNT_W-1:0] WK_EXT_DIV1 = 16'h0100;
  localparam logic [WK_CNT_W-1:0] WK_EXT_DIV2 = 16'h0400;
  localparam logic [WK_CNT_W-1:0] WK_EXT_DIV3 = 16'h0800;
  localparam logic [WK_CNT_W-1:0] WK_EXT_DIV4 = 16'h1000;
  localparam logic [WK_CNT_W-1:0] WK_EXT_DIV5 = 16'h2000;
  localparam logic [WK_CNT_W-1:0] WK_EXT_DIV6 = 16'h4000;
  localparam logic [WK_CNT_W-1:0] WK_EXT_DIV7 = 16'h8000;

  // Interrupt status/mask layout.
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_WAKEUP_BIT = 0;
  localparam int unsigned IRQ_OPT_REFUSED_BIT = 1;

  localparam int unsigned SYNC_W = 3;
  localparam int unsigned PART_W = 12;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } sowr_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [APB_DW-1:0] prdata;
  } sowr_apb_rsp_t;

endpackage : sowr_pkg

// ==== verif/tb.sv ====
// Self-checking testbench for the system options, part number and wakeup register block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sowr_pkg::*;
  // Arbitrary part number, chosen only to differ from the design default.
  localparam logic [PART_W-1:0] PART = 12'h6b9;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  sowr_apb_req_t req = '0;
  sowr_apb_rsp_t rsp;
  logic osc_pin = 1'b0;
  logic ext_pin = 1'b0;
  logic stop_exec = 1'b0;
  logic wd_en, wd_long, halt_p, stop_gr, ill_rst, dbg_pin, wk_irq, irq;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int n_tests = 0;

  always #20 clk_sys = ~clk_sys;

  sowr_regs #(.PART_NUMBER(PART)) DUT (
    .clk_sys(clk_sys),
    .srst(srst),
    .apb_req(req),
    .apb_rsp(rsp),
    .wakeup_osc_clk(osc_pin),
    .ext_clk(ext_pin),
    .stop_exec(stop_exec),
    .watchdog_enable(wd_en),
    .watchdog_long_timeout(wd_long),
    .halt_permit(halt_p),
    .stop_granted(stop_gr),
    .illegal_opcode_reset(ill_rst),
    .debug_pin_enable(dbg_pin),
    .wakeup_irq(wk_irq),
    .irq(irq)
  );

  task complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // The request is held until pready is sampled high; data is taken at that edge only.
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= wd;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (rsp.pready === 1'b1) break;
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    if (i == 50) check(32'h0, 32'h1, "bus answer missing");
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task rd_check(input logic [7:0] addr, input logic [31:0] exp, input string what);
    apb(1'b0, addr, 32'h0);
    check(rd, exp, what);
  endtask : rd_check

  function automatic logic [31:0] opt_pins();
    return {28'h0, wd_en, wd_long, halt_p, dbg_pin};
  endfunction : opt_pins

  // Each pulse is four cycles high and four low, slow enough for the pin synchroniser.
  task pulses(input logic sel, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (sel) ext_pin <= 1'b1;
      else osc_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_pin <= 1'b0;
      osc_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask : pulses

  task t_halt(input logic permit);
    @(posedge clk_sys);
    stop_exec <= 1'b1;
    @(posedge clk_sys);
    stop_exec <= 1'b0;
    @(negedge clk_sys);
    check({30'h0, stop_gr, ill_rst}, {30'h0, permit, !permit}, "halt answer");
    @(negedge clk_sys);
    check({30'h0, stop_gr, ill_rst}, 32'h0, "halt answer length");
  endtask : t_halt

  task t_options;
    rd_check(OFS_SYSTEM_OPTIONS, 32'hc2, "options reset");
    check(opt_pins(), 32'hd, "options outputs reset");
    t_halt(1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_SYSTEM_OPTIONS, 32'h3d);
    rd_check(OFS_SYSTEM_OPTIONS, 32'h20, "options first write");
    check(opt_pins(), 32'h2, "options outputs written");
    apb(1'b1, OFS_SYSTEM_OPTIONS, 32'hff);
    rd_check(OFS_SYSTEM_OPTIONS, 32'h20, "options second write");
    check(opt_pins(), 32'h2, "options outputs locked");
    t_halt(1'b1);
    rd_check(OFS_IRQ_STATUS, 32'h2, "refused write status");
    check({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h1, "irq unmasked");
    apb(1'b1, OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rd_check(OFS_IRQ_STATUS, 32'h0, "status cleared");
  endtask : t_options

  task t_part;
    rd_check(OFS_PART_NUMBER_HIGH, {28'h0, PART[11:8]}, "part high");
    rd_check(OFS_PART_NUMBER_LOW, {24'h0, PART[7:0]}, "part low");
    apb(1'b1, OFS_PART_NUMBER_LOW, 32'hff);
    rd_check(OFS_PART_NUMBER_LOW, {24'h0, PART[7:0]}, "part low after write");
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
  endtask : t_part

  // Bit 3 is written as one to show that it reads back as zero.
  task t_wake(input logic sel, input logic [2:0] code, input int n);
    logic [7:0] cfg;
    logic [7:0] exp;
    cfg = {2'b00, sel, 2'b11, code};
    exp = {2'b00, sel, 2'b10, code};
    apb(1'b1, OFS_WAKEUP_STATUS_CONTROL, {24'h0, cfg});
    pulses(sel, n - 1);
    rd_check(OFS_WAKEUP_STATUS_CONTROL, {24'h0, exp}, "flag early");
    check({31'h0, wk_irq}, 32'h0, "wakeup irq early");
    pulses(sel, 1);
    rd_check(OFS_WAKEUP_STATUS_CONTROL, {24'h0, exp | 8'h80}, "flag set");
    check({31'h0, wk_irq}, 32'h1, "wakeup irq set");
    rd_check(OFS_IRQ_STATUS, 32'h1, "wakeup status");
    apb(1'b1, OFS_WAKEUP_STATUS_CONTROL, {24'h0, cfg});
    rd_check(OFS_WAKEUP_STATUS_CONTROL, {24'h0, exp | 8'h80}, "zero does not clear");
    apb(1'b1, OFS_WAKEUP_STATUS_CONTROL, {24'h0, cfg | 8'h40});
    rd_check(OFS_WAKEUP_STATUS_CONTROL, {24'h0, exp}, "flag cleared");
    check({31'h0, wk_irq}, 32'h0, "wakeup irq cleared");
    apb(1'b1, OFS_IRQ_STATUS, 32'h1);
    rd_check(OFS_IRQ_STATUS, 32'h0, "wakeup status cleared");
  endtask : t_wake

  task t_ext_off;
    apb(1'b1, OFS_WAKEUP_STATUS_CONTROL, 32'h20);
    pulses(1'b1, 300);
    rd_check(OFS_WAKEUP_STATUS_CONTROL, 32'h20, "external code zero");
  endtask : t_ext_off

  task t_rereset;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd_check(OFS_SYSTEM_OPTIONS, 32'hc2, "options after reset");
    check(opt_pins(), 32'hd, "outputs after reset");
  endtask : t_rereset

  initial begin
    #(40 * 60000);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_options();
    t_part();
    t_wake(1'b0, 3'd0, 8);
    t_wake(1'b0, 3'd2, 32);
    t_wake(1'b0, 3'd7, 1024);
    t_wake(1'b1, 3'd1, 256);
    t_wake(1'b1, 3'd3, 2048);
    t_ext_off();
    t_rereset();
    complete_run();
  end
endmodule : tb
`default_nettype wire
